// ==== core/pcf_formatter.sv ====
`timescale 1ns/1ps
`default_nettype none

module pcf_formatter #(
  parameter bit         IS_COLOR   = 1'b1,
  parameter bit         BLUE_FIRST = 1'b1,
  parameter bit         HAS_WIDE   = 1'b1,
  parameter int unsigned ROI_W     = 12
) (
  input  wire logic               clock,
  input  wire logic               reset,
  input  wire logic [7:0]         pixel_format_code,
  input  wire logic               format_write,
  input  wire logic [ROI_W-1:0]   region_of_interest_x,
  input  wire logic [ROI_W-1:0]   region_of_interest_y,
  input  wire logic [ROI_W-1:0]   region_of_interest_w,
  input  wire logic [ROI_W-1:0]   region_of_interest_h,
  input  wire logic               region_write,
  input  wire pcf_pkg::pcf_pixel_t pix_in,
  input  wire logic               pix_valid,
  output logic                    pix_ready,
  output logic [1:0]              mosaic_alignment_code,
  output logic [7:0]              active_format_code,
  output logic                    format_rejected,
  output logic [ROI_W-1:0]        roi_x,
  output logic [ROI_W-1:0]        roi_y,
  output logic [ROI_W-1:0]        roi_w,
  output logic [ROI_W-1:0]        roi_h,
  output pcf_pkg::pcf_byte_t      byte_out,
  output logic                    byte_valid
);

  // Format code and region registers.
  logic [7:0]       fmt_q, fmt_d, pend_q, pend_d;
  logic             rej_q, rej_d, in_frame_q, in_frame_d;
  logic [ROI_W-1:0] rx_q, rx_d, ry_q, ry_d, rw_q, rw_d, rh_q, rh_d;
  logic             fmt_ok;

  // Sensor-side position parity tracks mosaic phase.
  logic             col_q, col_d, row_q, row_d;
  pcf_pkg::pcf_byte_t out_q, out_d;
  logic             vld_q, vld_d;
  logic             row_start;

  // Accepted format codes depend on the sensor flavour.
  always_comb begin
    unique case (pixel_format_code)
      pcf_pkg::FMT_GRAY8,
      pcf_pkg::FMT_LUMA_CHROMA,
      pcf_pkg::FMT_ALT_ORDER:   fmt_ok = 1'b1;
      pcf_pkg::FMT_GRAY16,
      pcf_pkg::FMT_GRAY12_PACK: fmt_ok = !IS_COLOR && HAS_WIDE;
      pcf_pkg::FMT_RAW8:        fmt_ok = IS_COLOR;
      pcf_pkg::FMT_RAW16,
      pcf_pkg::FMT_RAW12_PACK:  fmt_ok = IS_COLOR && HAS_WIDE;
      default:                  fmt_ok = 1'b0;
    endcase
  end

  // Control next state: a written code waits for the frame boundary.
  always_comb begin
    pend_d     = pend_q;
    rej_d      = rej_q;
    fmt_d      = fmt_q;
    in_frame_d = in_frame_q;
    rx_d       = rx_q;
    ry_d       = ry_q;
    rw_d       = rw_q;
    rh_d       = rh_q;
    if (format_write) begin
      rej_d = !fmt_ok;
      if (fmt_ok) begin
        pend_d = pixel_format_code;
      end
    end
    if (region_write) begin
      // Colour sensors clear the low bit so the mosaic phase is kept.
      rx_d = IS_COLOR ? {region_of_interest_x[ROI_W-1:1], 1'b0} : region_of_interest_x;
      ry_d = IS_COLOR ? {region_of_interest_y[ROI_W-1:1], 1'b0} : region_of_interest_y;
      rw_d = IS_COLOR ? {region_of_interest_w[ROI_W-1:1], 1'b0} : region_of_interest_w;
      rh_d = IS_COLOR ? {region_of_interest_h[ROI_W-1:1], 1'b0} : region_of_interest_h;
    end
    if (pix_valid) begin
      in_frame_d = !pix_in.frame_end;
      if (!in_frame_q) begin
        fmt_d = pend_q;
      end
    end else if (!in_frame_q) begin
      fmt_d = pend_q;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      pend_q     <= pcf_pkg::FMT_GRAY8;
      fmt_q      <= pcf_pkg::FMT_GRAY8;
      rej_q      <= 1'b0;
      in_frame_q <= 1'b0;
      rx_q       <= '0;
      ry_q       <= '0;
      rw_q       <= '0;
      rh_q       <= '0;
    end else begin
      pend_q     <= pend_d;
      fmt_q      <= fmt_d;
      rej_q      <= rej_d;
      in_frame_q <= in_frame_d;
      rx_q       <= rx_d;
      ry_q       <= ry_d;
      rw_q       <= rw_d;
      rh_q       <= rh_d;
    end
  end

  // Byte stream next state: one byte per pixel, in arrival order.
  always_comb begin
    logic [1:0] phase;
    phase     = 2'h0;
    col_d     = col_q;
    row_d     = row_q;
    out_d     = out_q;
    vld_d     = 1'b0;
    row_start = pix_in.first_pixel || !in_frame_q;
    if (pix_valid) begin
      phase = {row_start ? 1'b0 : row_q, row_start ? 1'b0 : col_q};
      // Even row: B,G or R,G; odd row: G,R or G,B.
      unique case (phase)
        2'h0:    out_d.color = BLUE_FIRST ? pcf_pkg::PCF_BLUE : pcf_pkg::PCF_RED;
        2'h3:    out_d.color = BLUE_FIRST ? pcf_pkg::PCF_RED : pcf_pkg::PCF_BLUE;
        default: out_d.color = pcf_pkg::PCF_GREEN;
      endcase
      out_d.data        = pix_in.level;
      out_d.frame_start = row_start;
      out_d.frame_end   = pix_in.frame_end;
      vld_d             = 1'b1;
      // Advance left to right, then down one line.
      col_d = pix_in.line_end ? 1'b0 : !phase[0];
      row_d = pix_in.line_end ? !phase[1] : phase[1];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      col_q <= 1'b0;
      row_q <= 1'b0;
      out_q <= '0;
      vld_q <= 1'b0;
    end else begin
      col_q <= col_d;
      row_q <= row_d;
      out_q <= out_d;
      vld_q <= vld_d;
    end
  end

  // Static alignment report; fixed because the region moves in pairs.
  assign mosaic_alignment_code = BLUE_FIRST ? pcf_pkg::ALIGN_BG_GR : pcf_pkg::ALIGN_RG_GB;
  assign active_format_code    = fmt_q;
  assign format_rejected       = rej_q;
  assign roi_x                 = rx_q;
  assign roi_y                 = ry_q;
  assign roi_w                 = rw_q;
  assign roi_h                 = rh_q;
  assign byte_out              = out_q;
  assign byte_valid            = vld_q;
  assign pix_ready             = 1'b1;

  // One pixel in gives exactly its byte on the next cycle.
  gray_byte_a : assert property (@(posedge clock) disable iff (reset)
    pix_valid |=> byte_valid && byte_out.data == $past(pix_in.level))
    else $error("pixel byte lost or changed");

  // Unsigned level passes unchanged.
  level_map_a : assert property (@(posedge clock) disable iff (reset)
    byte_valid |-> byte_out.data == $past(pix_in.level))
    else $error("level not unsigned pass-through");

  sequence line_head_s;
    pix_valid && pix_in.first_pixel && !pix_in.line_end;
  endsequence

  // First pixel of a frame takes the first mosaic colour, the next green.
  first_pair_a : assert property (@(posedge clock) disable iff (reset)
    line_head_s ##1 (pix_valid && !pix_in.first_pixel) |=> byte_out.color == pcf_pkg::PCF_GREEN &&
      $past(byte_out.color) == (BLUE_FIRST ? pcf_pkg::PCF_BLUE : pcf_pkg::PCF_RED))
    else $error("mosaic start wrong");

  // Region values on colour sensors stay even.
  roi_even_a : assert property (@(posedge clock) disable iff (reset)
    IS_COLOR |-> !rx_q[0] && !ry_q[0] && !rw_q[0] && !rh_q[0])
    else $error("odd region step");

  // Code matches the configured alignment.
  align_code_a : assert property (@(posedge clock) disable iff (reset)
    mosaic_alignment_code == (BLUE_FIRST ? 2'h3 : 2'h0))
    else $error("alignment code wrong");

  // A legal write outside a frame is in force two cycles later.
  fmt_take_a : assert property (@(posedge clock) disable iff (reset)
    format_write && fmt_ok && !in_frame_q && !pix_valid ##1 !format_write && !pix_valid
      |=> active_format_code == $past(pixel_format_code, 2))
    else $error("format not applied");

  // Illegal codes are flagged and never reach the active setting.
  fmt_reject_a : assert property (@(posedge clock) disable iff (reset)
    format_write && !fmt_ok |=> format_rejected && pend_q == $past(pend_q))
    else $error("illegal format accepted");

  // After a line end the next line starts at column zero; a frame's first line is row zero.
  line_wrap_a : assert property (@(posedge clock) disable iff (reset)
    pix_valid && pix_in.line_end
      |=> !col_q && row_q == ($past(row_start) ? 1'b1 : !$past(row_q)))
    else $error("line order broken");

endmodule : pcf_formatter

`default_nettype wire

// ==== pkg/pcf_pkg.sv ====
package pcf_pkg;

  // Mosaic alignment codes reported to the host.
  localparam logic [1:0] ALIGN_RG_GB = 2'h0;
  localparam logic [1:0] ALIGN_GB_RG = 2'h1;
  localparam logic [1:0] ALIGN_GR_BG = 2'h2;
  localparam logic [1:0] ALIGN_BG_GR = 2'h3;

  // Pixel format codes written by the host.
  localparam logic [7:0] FMT_GRAY8       = 8'h00;
  localparam logic [7:0] FMT_LUMA_CHROMA = 8'h01;
  localparam logic [7:0] FMT_RAW8        = 8'h09;
  localparam logic [7:0] FMT_GRAY16      = 8'h05;
  localparam logic [7:0] FMT_RAW16       = 8'h0A;
  localparam logic [7:0] FMT_ALT_ORDER   = 8'h80;
  localparam logic [7:0] FMT_RAW12_PACK  = 8'h86;
  localparam logic [7:0] FMT_GRAY12_PACK = 8'h84;

  // Mosaic colour of one pixel.
  typedef enum logic [1:0] {
    PCF_RED,
    PCF_GREEN,
    PCF_BLUE
  } pcf_color_t;

  // One pixel of the sensor stream.
  typedef struct packed {
    logic       first_pixel;
    logic       line_end;
    logic       frame_end;
    logic [7:0] level;
  } pcf_pixel_t;

  // One byte of the output stream with its mosaic tag.
  typedef struct packed {
    logic       frame_start;
    logic       frame_end;
    pcf_color_t color;
    logic [7:0] data;
  } pcf_byte_t;

endpackage : pcf_pkg

// ==== test/pcf_host_buffer.sv ====
`timescale 1ns/1ps
`default_nettype none
// Host image buffer: stores the first 64 received bytes in arrival order.
module pcf_host_buffer (
  input  wire logic               clock,
  input  wire logic               reset,
  input  wire pcf_pkg::pcf_byte_t byte_in,
  input  wire logic               byte_valid,
  output var int unsigned         count
);
  pcf_pkg::pcf_byte_t mem [0:63];
  // Appends one byte per valid cycle, so no padding can slip in.
  always_ff @(posedge clock) begin
    if (reset) begin
      count <= 0;
    end else if (byte_valid && count < 64) begin
      mem[count] <= byte_in;
      count <= count + 1;
    end
  end
endmodule : pcf_host_buffer
`default_nettype wire

// ==== test/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("BAD t=%0t got %h exp %h", $time, got, exp); end end
module testbench;
  logic               clock = 0, reset = 1, fmt_wr = 0, r_wr = 0, pix_valid = 0;
  logic [7:0]         fmt_code = 8'h00, act_fmt, act_fmt_m;
  logic [11:0]        rx = 12'h000, ry = 12'h000, rw = 12'h000, rh = 12'h000;
  logic [11:0]        ox, oy, ow, oh;
  logic [1:0]         align, align_m;
  logic               pix_ready, rej, bvalid, rej_m;
  pcf_pkg::pcf_pixel_t pix = '0;
  pcf_pkg::pcf_byte_t bout;
  int unsigned        count, n_mismatch = 0, n_checks = 0;
  pcf_formatter #(.IS_COLOR(1'b1), .BLUE_FIRST(1'b1), .HAS_WIDE(1'b1), .ROI_W(12))
    i_pcf_formatter (.clock(clock), .reset(reset), .pixel_format_code(fmt_code),
    .format_write(fmt_wr), .region_of_interest_x(rx), .region_of_interest_y(ry),
    .region_of_interest_w(rw), .region_of_interest_h(rh), .region_write(r_wr),
    .pix_in(pix), .pix_valid(pix_valid), .pix_ready(pix_ready),
    .mosaic_alignment_code(align), .active_format_code(act_fmt), .format_rejected(rej),
    .roi_x(ox), .roi_y(oy), .roi_w(ow), .roi_h(oh), .byte_out(bout), .byte_valid(bvalid));
  // Monochrome red-first flavour on the same inputs, for its format list and alignment code.
  pcf_formatter #(.IS_COLOR(1'b0), .BLUE_FIRST(1'b0), .HAS_WIDE(1'b1), .ROI_W(12))
    i_pcf_formatter_mono (.clock(clock), .reset(reset), .pixel_format_code(fmt_code),
    .format_write(fmt_wr), .region_of_interest_x(rx), .region_of_interest_y(ry),
    .region_of_interest_w(rw), .region_of_interest_h(rh), .region_write(r_wr),
    .pix_in(pix), .pix_valid(pix_valid), .pix_ready(),
    .mosaic_alignment_code(align_m), .active_format_code(act_fmt_m), .format_rejected(rej_m),
    .roi_x(), .roi_y(), .roi_w(), .roi_h(), .byte_out(), .byte_valid());
  pcf_host_buffer i_pcf_host_buffer (.clock(clock), .reset(reset), .byte_in(bout),
    .byte_valid(bvalid), .count(count));
  // Clock at 125 MHz.
  always #4 clock = ~clock;
  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict
  // Reset values and the constant alignment codes of the blue-first and the red-first sensor.
  task automatic check_reset();
    `CHK(align, pcf_pkg::ALIGN_BG_GR)
    `CHK(align_m, pcf_pkg::ALIGN_RG_GB)
    `CHK(act_fmt, pcf_pkg::FMT_GRAY8)
    `CHK(rej, 1'b0)
    `CHK(pix_ready, 1'b1)
  endtask : check_reset
  // Writes every code of the colour flavour plus illegal ones; refused codes are flagged and leave the active format unchanged.
  task automatic check_formats();
    logic [7:0] codes [9] = '{8'h09, 8'h05, 8'h0A, 8'h84, 8'h86, 8'h80, 8'hFF, 8'h01, 8'h00};
    logic       bad   [9] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
    logic       bad_m [9] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    logic [7:0] exp_fmt, exp_fmt_m;
    exp_fmt   = act_fmt;
    exp_fmt_m = act_fmt_m;
    foreach (codes[i]) begin
      @(posedge clock);
      fmt_code <= codes[i];
      fmt_wr   <= 1'b1;
      @(posedge clock);
      fmt_wr <= 1'b0;
      repeat (2) @(posedge clock);
      #1;
      if (!bad[i]) exp_fmt = codes[i];
      if (!bad_m[i]) exp_fmt_m = codes[i];
      `CHK(rej, bad[i])
      `CHK(act_fmt, exp_fmt)
      `CHK(rej_m, bad_m[i])
      `CHK(act_fmt_m, exp_fmt_m)
    end
  endtask : check_formats
  // Odd region values must fall back to even steps on a colour sensor.
  task automatic check_region();
    @(posedge clock);
    {rx, ry, rw, rh} <= {12'h005, 12'h0A1, 12'h7FF, 12'h0F2};
    r_wr <= 1'b1;
    @(posedge clock);
    r_wr <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    `CHK({ox, oy, ow, oh}, {12'h004, 12'h0A0, 12'h7FE, 12'h0F2})
  endtask : check_region
  // Two lines of four back-to-back pixels in gray 8, with the extreme levels.
  task automatic check_frame();
    logic [7:0] lv [8] = '{8'h00, 8'hFF, 8'h01, 8'hFE, 8'h80, 8'h7F, 8'h55, 8'hAA};
    pcf_pkg::pcf_color_t col;
    int unsigned base, k;
    base = count;
    for (int i = 0; i < 8; i++) begin
      @(posedge clock);
      pix_valid <= 1'b1;
      pix <= '{first_pixel: i == 0, line_end: i % 4 == 3, frame_end: i == 7, level: lv[i]};
    end
    @(posedge clock);
    pix_valid <= 1'b0;
    for (k = 0; k < 20 && count < base + 8; k++) @(posedge clock);
    #1;
    `CHK(count, base + 8)
    if (count < base + 8) give_verdict();
    for (int i = 0; i < 8; i++) begin
      if (i / 4 == 0) col = (i % 2 == 0) ? pcf_pkg::PCF_BLUE : pcf_pkg::PCF_GREEN;
      else col = (i % 2 == 0) ? pcf_pkg::PCF_GREEN : pcf_pkg::PCF_RED;
      `CHK(i_pcf_host_buffer.mem[base+i].data, lv[i])
      `CHK(i_pcf_host_buffer.mem[base+i].color, col)
      `CHK(i_pcf_host_buffer.mem[base+i].frame_start, 1'(i == 0))
      `CHK(i_pcf_host_buffer.mem[base+i].frame_end, 1'(i == 7))
    end
  endtask : check_frame
  // Main sequence: reset, then each scenario, then a second frame for a restarted phase.
  initial begin
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    #1;
    check_reset();
    check_formats();
    check_region();
    check_frame();
    check_frame();
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
